//--- iem_pkg.sv
// Purpose: Shared constants for the interrupt enable mask block.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes: Register offsets are word indices; byte address is four times the index.
package iem_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int IEM_SRC_N = 6;
  localparam int IEM_ADDR_W = 12;
  localparam int IEM_DATA_W = 32;
  localparam int IEM_REG_W = 8;

  // ==========================================================================
  // Register indices
  // ==========================================================================
  localparam logic [7:0] IEM_PEND_IDX = 8'hFA;
  localparam logic [7:0] IEM_MASK_IDX = 8'hFB;
  localparam logic [7:0] IEM_STAT_IDX = 8'hFC;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int IEM_MASTER_BIT = 7;
  localparam int IEM_RSVD_BIT = 6;
  localparam int IEM_EDGE_HI = 7;
  localparam int IEM_EDGE_LO = 6;
  localparam int IEM_SRC_HI = 5;
  localparam int IEM_STAT_UNLOCK_BIT = 0;
  localparam int IEM_STAT_HALT_BIT = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic IEM_MASTER_RST = 1'h0;
  localparam logic IEM_RSVD_RST = 1'h1;
  localparam logic [5:0] IEM_EN_RST = 6'h00;
  localparam logic [5:0] IEM_PEND_RST = 6'h00;
  localparam logic [1:0] IEM_EDGE_RST = 2'h0;

endpackage

//--- iem_gate_if.sv
// Purpose: Carries latched requests and enables to the gating stage.
// Assumes: One clock domain; the gating stage is combinational.
// Notes: The controller drives the state, the gate returns the deliverable set.
`timescale 1ns/1ps

interface iem_gate_if #(
  parameter int SRC_N = 6
);
  logic [SRC_N-1:0] pending;
  logic [SRC_N-1:0] enable;
  logic master;
  logic [SRC_N-1:0] deliver;

  modport ctrl (output pending, output enable, output master, input deliver);
  modport gate (input pending, input enable, input master, output deliver);
endinterface

//--- iem_gate.sv
// Purpose: Gates each latched request by its own enable and the master enable.
// Assumes: Inputs are flip-flop outputs of the controller.
// Notes: Purely combinational; the controller registers the result.
`timescale 1ns/1ps

module iem_gate #(
  parameter int SRC_N = 6
) (
  iem_gate_if.gate gif
);

  // ==========================================================================
  // Per-source gating
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < SRC_N; i++) begin : g_src
      assign gif.deliver[i] = gif.master & gif.enable[i] & gif.pending[i]; // R4
    end
  endgenerate

endmodule // iem_gate

//--- iem_top.sv
// Purpose: Interrupt enable mask with pending latch, APB registers and halt wake.
// Assumes: APB master per the usual protocol; core instruction strobes are pulses.
// Notes: Every APB access takes one wait state; outputs are all registered.
// Operation
// (R1) Bits 5..0 of the mask enable their matching request source.
// (R2) Bit 7 of the mask reads back the global enable state.
// (R3) Reset clears the global enable so nothing reaches the core.
// (R4) Global enable low blocks all; high passes per-source enabled requests.
// (R5) Core alters global enable only by disable/enable instructions, disabling before writes.
// (R6) Writing one to bit 7 needs the enable instruction too.
// (R7) Bit 6 is reserved, reads undefined, software always writes one.
// (R8) Service clears a pending bit; software writes set or clear it.
// (R9) Pending writes are ignored until the enable instruction ran once.
// (R10) Halt keeps interrupts alive; only an enabled request ends it.
// (R11) A masked pending request stays latched until both enables allow it.
`timescale 1ns/1ps

module iem_top
  import iem_pkg::*;
#(
  parameter int SRC_N = IEM_SRC_N
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IEM_ADDR_W-1:0] paddr,
  input wire logic [IEM_DATA_W-1:0] pwdata,
  output logic [IEM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SRC_N-1:0] request_source,
  input wire logic [SRC_N-1:0] service_ack,
  input wire logic disable_interrupts_instruction,
  input wire logic enable_interrupts_instruction,
  input wire logic halt_req,
  output logic [SRC_N-1:0] irq_request,
  output logic halted,
  output logic wake
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic reg_hit(input logic [IEM_ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  logic [IEM_DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic master_r;
  logic rsvd_r;
  logic [SRC_N-1:0] en_r;
  logic [SRC_N-1:0] pend_r;
  logic [SRC_N-1:0] pend_nxt;
  logic [1:0] edge_r;
  logic unlock_r;
  logic halted_r;
  logic wake_r;
  logic [SRC_N-1:0] irq_r;
  logic acc_first;
  logic wr_do;
  logic hit_mask;
  logic hit_pend;
  logic hit_stat;
  logic pend_wr_ok;

  iem_gate_if #(.SRC_N(SRC_N)) gif ();

  assign gif.pending = pend_r;
  assign gif.enable = en_r;
  assign gif.master = master_r;

  iem_gate #(.SRC_N(SRC_N)) u_gate (
    .gif(gif.gate)
  );

  assign hit_mask = reg_hit(paddr, IEM_MASK_IDX);
  assign hit_pend = reg_hit(paddr, IEM_PEND_IDX);
  assign hit_stat = reg_hit(paddr, IEM_STAT_IDX);
  // The first access cycle computes the answer; the second one commits it.
  assign acc_first = psel & penable & ~pready_r;
  assign wr_do = psel & penable & pready_r & pwrite;
  assign pend_wr_ok = wr_do & hit_pend & unlock_r; // R9

  // ==========================================================================
  // APB answer
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc_first;
      pslverr_r <= acc_first & ~(hit_mask | hit_pend | hit_stat);
      prdata_r <= '0;
      if (acc_first && !pwrite) begin
        if (hit_mask) begin
          prdata_r[IEM_MASTER_BIT] <= master_r; // R2
          prdata_r[IEM_RSVD_BIT] <= rsvd_r; // R7
          prdata_r[IEM_SRC_HI:0] <= en_r;
        end else if (hit_pend) begin
          prdata_r[IEM_EDGE_HI:IEM_EDGE_LO] <= edge_r;
          prdata_r[IEM_SRC_HI:0] <= pend_r;
        end else if (hit_stat) begin
          prdata_r[IEM_STAT_UNLOCK_BIT] <= unlock_r; // R9
          prdata_r[IEM_STAT_HALT_BIT] <= halted_r;
        end
      end
    end
  end

  // ==========================================================================
  // Mask register
  // ==========================================================================
  // Bit 7 is not written by the bus: the core's instructions own it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_r <= IEM_EN_RST;
      rsvd_r <= IEM_RSVD_RST;
    end else if (wr_do && hit_mask) begin
      en_r <= pwdata[IEM_SRC_HI:0]; // R1
      rsvd_r <= pwdata[IEM_RSVD_BIT]; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      master_r <= IEM_MASTER_RST; // R3
    end else if (disable_interrupts_instruction) begin
      master_r <= 1'h0; // R5
    end else if (enable_interrupts_instruction) begin
      master_r <= 1'h1; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unlock_r <= 1'h0;
    end else if (enable_interrupts_instruction) begin
      unlock_r <= 1'h1; // R9
    end
  end

  // ==========================================================================
  // Pending latch
  // ==========================================================================
  // A new source event wins over both the service clear and a software clear.
  always_comb begin
    pend_nxt = pend_r; // R11
    if (pend_wr_ok) begin
      pend_nxt = pwdata[IEM_SRC_HI:0]; // R8
    end
    pend_nxt = (pend_nxt & ~service_ack) | request_source; // R8
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_r <= IEM_PEND_RST;
      edge_r <= IEM_EDGE_RST;
    end else begin
      pend_r <= pend_nxt;
      if (pend_wr_ok) begin
        edge_r <= pwdata[IEM_EDGE_HI:IEM_EDGE_LO];
      end
    end
  end

  // ==========================================================================
  // Delivery and halt
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_r <= '0;
    end else begin
      irq_r <= gif.deliver; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halted_r <= 1'h0;
      wake_r <= 1'h0;
    end else begin
      wake_r <= halted_r & (|gif.deliver); // R10
      if (halted_r && (|gif.deliver)) begin
        halted_r <= 1'h0; // R10
      end else if (halt_req) begin
        halted_r <= 1'h1;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_request = irq_r;
  assign halted = halted_r;
  assign wake = wake_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  en_write_a: assert property (wr_do && hit_mask |=> en_r == $past(pwdata[IEM_SRC_HI:0])) // R1
    else $error("Source enables did not take the written value.");

  master_read_a: assert property (acc_first && !pwrite && hit_mask
      |=> pready_r && prdata_r[IEM_MASTER_BIT] == $past(master_r)) // R2
    else $error("Mask read did not return the global enable.");

  reset_master_a: assert property ($past(!rst_b) |-> !master_r && irq_r == '0) // R3
    else $error("Global enable or requests not clear after reset.");

  gate_out_a: assert property (##1 irq_r == ($past(pend_r) & $past(en_r)
      & {SRC_N{$past(master_r)}})) // R4
    else $error("Delivered requests do not match the enables.");

  master_hold_a: assert property (!disable_interrupts_instruction
      && !enable_interrupts_instruction |=> master_r == $past(master_r)) // R5
    else $error("Global enable changed without an instruction.");

  rsvd_bit_a: assert property (wr_do && hit_mask |=> rsvd_r == $past(pwdata[IEM_RSVD_BIT])) // R7
    else $error("Reserved bit did not follow the write.");

  service_clr_a: assert property (!pend_wr_ok
      |=> (pend_r & $past(service_ack & ~request_source)) == '0) // R8
    else $error("Serviced request stayed pending.");

  pend_lock_a: assert property (!unlock_r && request_source == '0 && service_ack == '0
      |=> pend_r == $past(pend_r)) // R9
    else $error("Pending register changed while locked.");

  halt_wake_a: assert property (halted_r && (|gif.deliver) |=> !halted_r ##0 wake_r) // R10
    else $error("Enabled request did not end halt.");

  halt_stay_a: assert property (halted_r && !(|gif.deliver) |=> halted_r) // R10
    else $error("Halt ended without an enabled request.");

  latch_keep_a: assert property (!pend_wr_ok
      |=> ($past(pend_r & ~service_ack) & ~pend_r) == '0) // R11
    else $error("Masked pending request was lost.");

endmodule // iem_top

//--- iem_core_model.sv
// Purpose: Core-side model issuing enable, disable, halt and service strobes.
// Assumes: Strobes are one-cycle pulses changed just after a rising edge.
// Notes: The bench calls the tasks; the model never drives two at once.
`timescale 1ns/1ps

module iem_core_model (
  input wire logic clk,
  output logic disable_interrupts_instruction,
  output logic enable_interrupts_instruction,
  output logic halt,
  output logic [5:0] ack
);
  // ==========================================================================
  // Instruction strobes
  // ==========================================================================
  initial begin
    disable_interrupts_instruction = 1'h0;
    enable_interrupts_instruction = 1'h0;
    halt = 1'h0;
    ack = 6'h00;
  end

  task automatic disable_pulse();
    @(posedge clk) disable_interrupts_instruction <= 1'h1;
    @(posedge clk) disable_interrupts_instruction <= 1'h0;
  endtask

  task automatic enable_pulse();
    @(posedge clk) enable_interrupts_instruction <= 1'h1;
    @(posedge clk) enable_interrupts_instruction <= 1'h0;
  endtask

  task automatic halt_pulse();
    @(posedge clk) halt <= 1'h1;
    @(posedge clk) halt <= 1'h0;
  endtask

  task automatic serve(input logic [5:0] m);
    @(posedge clk) ack <= m;
    @(posedge clk) ack <= 6'h00;
  endtask
endmodule // iem_core_model

//--- interrupt_enable_mask_tb.sv
// Purpose: Self-checking bench for the interrupt enable mask block.
// Assumes: The block answers every APB access; the bench waits for pready.
// Notes: Mask writes always carry a one in the reserved bit.
`timescale 1ns/1ps

module interrupt_enable_mask_tb;
  import iem_pkg::*;
  localparam logic [11:0] A_PEND = {2'h0, IEM_PEND_IDX, 2'h0};
  localparam logic [11:0] A_MASK = {2'h0, IEM_MASK_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, IEM_STAT_IDX, 2'h0};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, woke;
  logic [5:0] src = 6'h00, irq, ack;
  logic core_dis, core_ena, hreq, halted, wake;
  int errors = 0, num_checks = 0, cyc = 0;

  iem_top u_iem_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .request_source(src), .service_ack(ack),
    .disable_interrupts_instruction(core_dis), .enable_interrupts_instruction(core_ena),
    .halt_req(hreq), .irq_request(irq), .halted(halted), .wake(wake));
  iem_core_model u_iem_core_model (.clk(clk), .disable_interrupts_instruction(core_dis),
    .enable_interrupts_instruction(core_ena), .halt(hreq), .ack(ack));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    forever #25 clk = ~clk;
  end

  // A hang in any wait ends here rather than running forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    apb(1'h0, A_MASK, 32'h0);
    chk("mask", rd & 32'hBF, 32'h00);
    chk("irq", irq, 6'h00);
    chk("err", er, 1'h0);
    $display("reset test done");
  endtask

  task automatic t_locked();
    u_iem_core_model.disable_pulse();
    apb(1'h1, A_MASK, 32'hC5);
    apb(1'h0, A_MASK, 32'h0);
    chk("mask", rd & 32'hBF, 32'h05);
    apb(1'h1, A_PEND, 32'h3F);
    apb(1'h0, A_PEND, 32'h0);
    chk("pend", rd, 32'h00);
    @(posedge clk) src <= 6'h3F;
    @(posedge clk) src <= 6'h00;
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h00);
    u_iem_core_model.enable_pulse();
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h05);
    apb(1'h0, A_MASK, 32'h0);
    chk("mask", rd & 32'hBF, 32'h85);
    $display("enable test done");
  endtask

  task automatic t_pend();
    u_iem_core_model.serve(6'h05);
    apb(1'h0, A_PEND, 32'h0);
    chk("pend", rd, 32'h3A);
    chk("irq", irq, 6'h00);
    apb(1'h1, A_PEND, 32'h00);
    apb(1'h0, A_PEND, 32'h0);
    chk("pend", rd, 32'h00);
    apb(1'h1, A_PEND, 32'hC4);
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h04);
    apb(1'h0, A_PEND, 32'h0);
    chk("pend", rd, 32'hC4);
    apb(1'h1, A_PEND, 32'h08);
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h00);
    apb(1'h0, 12'h000, 32'h0);
    chk("err", {rd[30:0], er}, 32'h1);
    $display("pending test done");
  endtask

  task automatic t_halt();
    u_iem_core_model.halt_pulse();
    repeat (5) @(posedge clk);
    chk("halted", halted, 1'h1);
    apb(1'h0, A_STAT, 32'h0);
    chk("stat", rd, 32'h03);
    @(posedge clk) src <= 6'h01;
    @(posedge clk) src <= 6'h00;
    woke = 1'h0;
    repeat (6) begin
      @(posedge clk);
      if (wake === 1'h1) woke = 1'h1;
    end
    chk("wake", woke, 1'h1);
    chk("halted", halted, 1'h0);
    u_iem_core_model.disable_pulse();
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h00);
    $display("halt test done");
  endtask

  // A second reset in mid-run must drop an active global enable and relock pending.
  task automatic t_rerun();
    u_iem_core_model.enable_pulse();
    repeat (3) @(posedge clk);
    chk("irq", irq, 6'h01);
    @(posedge clk) rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    chk("irq", irq, 6'h00);
    apb(1'h0, A_MASK, 32'h0);
    chk("mask", rd & 32'hBF, 32'h00);
    apb(1'h0, A_STAT, 32'h0);
    chk("stat", rd, 32'h00);
    apb(1'h1, A_PEND, 32'h3F);
    apb(1'h0, A_PEND, 32'h0);
    chk("pend", rd, 32'h00);
    $display("reset rerun test done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_locked();
    t_pend();
    t_halt();
    t_rerun();
    tally_and_finish();
  end
endmodule // interrupt_enable_mask_tb
